//--- tw_pkg.sv
// Purpose: shared constants for the two-wire register access slave and its master
// Assumes: 40 MHz system clock on both ends
// Notes: the master makes the serial clock by dividing its own clock
package tw_pkg;
  // system clock and serial clock timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 2500;
  // one quarter of a serial bit, in system clock cycles
  localparam logic [7:0] QTR_CYC = 8'(SCL_PERIOD_NS / 4 / CLK_PERIOD_NS);
  // upper six slave address bits, bit zero comes from the select pin
  localparam logic [5:0] ADDR_HI = 6'h16;
  // general call address byte
  localparam logic [7:0] GEN_CALL = 8'h00;
  // supported indices are below the limit, except the hole
  localparam logic [7:0] IDX_LIMIT = 8'h18;
  localparam logic [7:0] IDX_HOLE = 8'h09;
  // reset value of the register index
  localparam logic [7:0] IDX_RESET = 8'h00;
  // bits per byte on the wire, the ack follows as the ninth
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // master command codes
  localparam logic [1:0] OP_START = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_STOP = 2'h3;

  // true when the index names a register the core holds
  function automatic logic tw_idx_ok(input logic [7:0] idx);
    return (idx < IDX_LIMIT) && (idx != IDX_HOLE);
  endfunction : tw_idx_ok
endpackage : tw_pkg

//--- tw_if.sv
// Purpose: open-drain two-wire link between master and slave
// Assumes: both lines pulled high when nobody drives them
// Notes: the wire level is resolved here from the enables
`timescale 1ns/100ps
interface tw_if;
  logic scl_out; // master clock drive value
  logic scl_oe; // master pulls clock low while high
  logic m_sda_out; // master data drive value
  logic m_sda_oe; // master drives data while high
  logic s_sda_out; // slave data drive value
  logic s_sda_oe; // slave drives data while high
  logic scl; // resolved clock level
  logic sda; // resolved data level

  // open drain: any driver driving a zero pulls the line low
  assign scl = ~(scl_oe & ~scl_out);
  assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));

  modport master (output scl_out, output scl_oe, output m_sda_out, output m_sda_oe,
                  input scl, input sda);
  modport slave (output s_sda_out, output s_sda_oe, input scl, input sda);
endinterface : tw_if

//--- tw_sync.sv
// Purpose: two flip-flop synchroniser for pins from outside the clock domain
// Assumes: each bit is an independent level
// Notes: only the second stage may be read by logic
`timescale 1ns/100ps
module tw_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, read by q only

  // lines idle high, so reset to ones avoids a false start edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : tw_sync

//--- tw_slave.sv
// Purpose: two-wire slave giving a master byte access to an indexed register file
// Assumes: core read data is a combinational function of reg_index
// Notes: serial clock is oversampled; it must be far slower than clk
`timescale 1ns/100ps
module tw_slave import tw_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link
  tw_if.slave bus,
  // address select strap
  input wire logic addr_sel,
  // core register port
  output logic [7:0] reg_index,
  output logic index_valid,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  input wire logic [7:0] rd_data
);
  // one-hot protocol states
  typedef enum logic [8:0] {
    S_IDLE = 9'h001, // waiting for start
    S_ADDR = 9'h002, // shifting address byte
    S_AACK = 9'h004, // address ack bit
    S_IDX = 9'h008, // shifting index byte
    S_IACK = 9'h010, // index ack bit
    S_WDAT = 9'h020, // shifting write data
    S_WACK = 9'h040, // write data ack bit
    S_RDAT = 9'h080, // sending read data
    S_RACK = 9'h100 // master ack bit
  } tw_sst_t;

  logic [2:0] sync_q; // synchronised scl, sda, select
  logic scl_s; // synchronised clock
  logic sda_s; // synchronised data
  logic sel_s; // synchronised select
  logic scl_d; // clock one cycle back
  logic sda_d; // data one cycle back
  logic scl_rise; // clock rising edge
  logic scl_fall; // clock falling edge
  logic start_c; // start or repeated start seen
  logic stop_c; // stop seen
  logic [7:0] rd_load; // byte to send next

  tw_sst_t state, next_state; // protocol state
  logic [7:0] shift, next_shift; // serial shift register
  logic [3:0] cnt, next_cnt; // bit counter
  logic rw, next_rw; // direction bit of the address
  logic gc, next_gc; // general call in progress
  logic acked, next_acked; // last write byte was acked
  logic mack, next_mack; // master acked last read byte
  logic sda_oe, next_sda_oe; // pulling data low
  logic a0, next_a0; // low address bit
  logic [1:0] a0_done, next_a0_done; // cycles counted until the strap is caught
  logic [7:0] next_reg_index; // register index
  logic next_index_valid; // index names a real register
  logic [7:0] next_wr_data; // write data to core
  logic next_wr_strobe; // one-cycle write pulse

  // pins come from the master's domain, two flops first
  tw_sync #(.W(3)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({bus.scl, bus.sda, addr_sel}),
    .q(sync_q)
  );

  assign scl_s = sync_q[2];
  assign sda_s = sync_q[1];
  assign sel_s = sync_q[0];
  // edges and conditions from the synchronised samples only
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c = scl_s & scl_d & ~sda_d & sda_s;
  // unsupported index reads back as zero
  assign rd_load = index_valid ? rd_data : 8'h00;

  // open drain: drive only zeros
  assign bus.s_sda_out = 1'b0;
  assign bus.s_sda_oe = sda_oe;

  // next-state logic of the whole slave
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_cnt = cnt;
    next_rw = rw;
    next_gc = gc;
    next_acked = acked;
    next_mack = mack;
    next_sda_oe = sda_oe;
    next_a0 = a0;
    next_a0_done = a0_done;
    next_reg_index = reg_index;
    next_wr_data = wr_data;
    next_wr_strobe = 1'b0;
    // strap sampled until the synchroniser shows the pin, not its reset ones
    if (a0_done != 2'h3) begin
      next_a0 = sel_s;
      next_a0_done = a0_done + 2'h1;
    end
    if (start_c) begin
      // repeated start keeps the index for the read phase
      next_state = S_ADDR;
      next_cnt = 4'h0;
      next_sda_oe = 1'b0;
      next_gc = 1'b0;
    end else if (stop_c) begin
      next_state = S_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          next_sda_oe = 1'b0; // ignore traffic for others
        end
        S_ADDR, S_IDX, S_WDAT: begin
          if (scl_rise && cnt < BYTE_BITS) begin
            // sample on rising clock, msb first
            next_shift = {shift[6:0], sda_s};
            next_cnt = cnt + 4'h1;
          end else if (scl_fall && cnt == BYTE_BITS) begin
            next_cnt = 4'h0;
            if (state == S_ADDR) begin
              if (shift[7:1] == {ADDR_HI, a0}) begin
                next_sda_oe = 1'b1;
                next_rw = shift[0];
                next_state = S_AACK;
              end else if (shift == GEN_CALL) begin
                // general call reloads the low address bit
                next_a0 = sel_s;
                next_gc = 1'b1;
                next_sda_oe = 1'b1;
                next_state = S_AACK;
              end else begin
                next_state = S_IDLE; // not us
              end
            end else if (state == S_IDX) begin
              next_reg_index = shift;
              next_sda_oe = 1'b1;
              next_state = S_IACK;
            end else if (index_valid) begin
              next_wr_data = shift;
              next_wr_strobe = 1'b1;
              next_sda_oe = 1'b1;
              next_acked = 1'b1;
              next_state = S_WACK;
            end else begin
              // leave the line high, the master sees a nack
              next_sda_oe = 1'b0;
              next_acked = 1'b0;
              next_state = S_WACK;
            end
          end
        end
        S_AACK: begin
          if (scl_fall) begin
            next_cnt = 4'h0;
            if (gc) begin
              next_sda_oe = 1'b0;
              next_state = S_IDLE;
            end else if (rw) begin
              // first data bit goes out right away
              next_shift = rd_load;
              next_sda_oe = ~rd_load[7];
              next_state = S_RDAT;
            end else begin
              next_sda_oe = 1'b0;
              next_state = S_IDX;
            end
          end
        end
        S_IACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt = 4'h0;
            next_state = S_WDAT;
          end
        end
        S_WACK: begin
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_cnt = 4'h0;
            next_state = S_WDAT;
            if (acked) begin
              next_reg_index = reg_index + 8'h01;
            end
          end
        end
        S_RDAT: begin
          if (scl_fall) begin
            if (cnt == BYTE_BITS - 4'h1) begin
              // release so the master can ack
              next_sda_oe = 1'b0;
              next_reg_index = reg_index + 8'h01;
              next_state = S_RACK;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
              next_cnt = cnt + 4'h1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            next_mack = ~sda_s;
          end else if (scl_fall) begin
            next_cnt = 4'h0;
            if (mack) begin
              next_shift = rd_load;
              next_sda_oe = ~rd_load[7];
              next_state = S_RDAT;
            end else begin
              // nack ends the read, wait for stop
              next_state = S_IDLE;
            end
          end
        end
        default: begin
          next_state = S_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
    // valid flag is registered together with the index
    next_index_valid = tw_idx_ok(next_reg_index);
  end

  // registers only; the strap is taken after reset, never during it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= S_IDLE;
      shift <= 8'h00;
      cnt <= 4'h0;
      rw <= 1'b0;
      gc <= 1'b0;
      acked <= 1'b0;
      mack <= 1'b0;
      sda_oe <= 1'b0;
      a0 <= 1'b0;
      a0_done <= 2'h0;
      reg_index <= IDX_RESET;
      index_valid <= 1'b0;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      state <= next_state;
      shift <= next_shift;
      cnt <= next_cnt;
      rw <= next_rw;
      gc <= next_gc;
      acked <= next_acked;
      mack <= next_mack;
      sda_oe <= next_sda_oe;
      a0 <= next_a0;
      a0_done <= next_a0_done;
      reg_index <= next_reg_index;
      index_valid <= next_index_valid;
      wr_data <= next_wr_data;
      wr_strobe <= next_wr_strobe;
    end
  end
endmodule : tw_slave

//--- tw_master.sv
// Purpose: two-wire master issuing start, byte and stop commands
// Assumes: no clock stretching by the slave
// Notes: serial clock is divided from clk, four quarters per bit
`timescale 1ns/100ps
module tw_master import tw_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // serial link
  tw_if.master bus,
  // command port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic cmd_ready,
  // answers
  output logic done,
  output logic [7:0] rx_data,
  output logic rx_nack
);
  // one-hot sequencer states
  typedef enum logic [3:0] {
    M_IDLE = 4'h1, // waiting for a command
    M_START = 4'h2, // start or repeated start
    M_BYTE = 4'h4, // nine clock bits
    M_STOP = 4'h8 // stop condition
  } tw_mst_t;

  logic sda_s; // synchronised data line
  logic tick; // end of a quarter
  tw_mst_t state, next_state; // sequencer state
  logic [1:0] qtr, next_qtr; // quarter within a bit
  logic [7:0] tmr, next_tmr; // quarter timer
  logic [3:0] bitn, next_bitn; // bit within a byte
  logic [1:0] op, next_op; // command held
  logic [7:0] tx, next_tx; // bits left to send
  logic nack_cfg, next_nack_cfg; // ack value to send on read
  logic scl_oe, next_scl_oe; // pulling clock low
  logic sda_oe, next_sda_oe; // pulling data low
  logic next_cmd_ready; // can take a command
  logic next_done; // one-cycle completion
  logic [7:0] next_rx_data; // bytes read
  logic next_rx_nack; // slave nack on write

  // data line returns through the slave, so synchronise it
  tw_sync #(.W(1)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d(bus.sda),
    .q(sda_s)
  );

  assign tick = (tmr == 8'h00);
  assign bus.scl_out = 1'b0;
  assign bus.scl_oe = scl_oe;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe = sda_oe;

  // next values; each quarter's action happens at its end
  always_comb begin
    next_state = state;
    next_qtr = qtr;
    next_tmr = tick ? QTR_CYC : tmr - 8'h01;
    next_bitn = bitn;
    next_op = op;
    next_tx = tx;
    next_nack_cfg = nack_cfg;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_cmd_ready = cmd_ready;
    next_done = 1'b0;
    next_rx_data = rx_data;
    next_rx_nack = rx_nack;
    if (tick && state != M_IDLE) begin
      next_qtr = qtr + 2'h1;
    end
    case (state)
      M_IDLE: begin
        next_cmd_ready = 1'b1;
        next_qtr = 2'h0;
        next_tmr = QTR_CYC;
        if (cmd_valid && cmd_ready) begin
          next_cmd_ready = 1'b0;
          next_op = cmd_op;
          next_tx = cmd_data;
          next_nack_cfg = cmd_nack;
          next_bitn = 4'h0;
          if (cmd_op == OP_START) begin
            next_state = M_START;
          end else if (cmd_op == OP_STOP) begin
            next_state = M_STOP;
          end else begin
            next_state = M_BYTE;
          end
        end
      end
      M_START: begin
        // release data, raise clock, drop data, drop clock
        if (tick) begin
          case (qtr)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1;
            default: begin
              next_scl_oe = 1'b1;
              next_done = 1'b1;
              next_state = M_IDLE;
            end
          endcase
        end
      end
      M_STOP: begin
        // data low under low clock, raise clock, raise data
        if (tick) begin
          case (qtr)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              next_sda_oe = 1'b0;
              next_done = 1'b1;
              next_state = M_IDLE;
            end
            default: next_state = M_IDLE;
          endcase
        end
      end
      M_BYTE: begin
        if (tick) begin
          case (qtr)
            2'h0: begin
              // set data while clock is low, msb first
              if (bitn < BYTE_BITS) begin
                next_sda_oe = (op == OP_WRITE) ? ~tx[7] : 1'b0;
              end else begin
                next_sda_oe = (op == OP_WRITE) ? 1'b0 : ~nack_cfg;
              end
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              // sample in the middle of the high clock
              if (bitn < BYTE_BITS) begin
                next_tx = {tx[6:0], 1'b0};
                if (op == OP_READ) begin
                  next_rx_data = {rx_data[6:0], sda_s};
                end
              end else if (op == OP_WRITE) begin
                next_rx_nack = sda_s;
              end
            end
            default: begin
              next_scl_oe = 1'b1;
              if (bitn == BYTE_BITS) begin
                next_sda_oe = 1'b0;
                next_done = 1'b1;
                next_state = M_IDLE;
              end else begin
                next_bitn = bitn + 4'h1;
              end
            end
          endcase
        end
      end
      default: next_state = M_IDLE;
    endcase
  end

  // registers only; link released during reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= M_IDLE;
      qtr <= 2'h0;
      tmr <= 8'h00;
      bitn <= 4'h0;
      op <= OP_START;
      tx <= 8'h00;
      nack_cfg <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      rx_data <= 8'h00;
      rx_nack <= 1'b0;
    end else begin
      state <= next_state;
      qtr <= next_qtr;
      tmr <= next_tmr;
      bitn <= next_bitn;
      op <= next_op;
      tx <= next_tx;
      nack_cfg <= next_nack_cfg;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      cmd_ready <= next_cmd_ready;
      done <= next_done;
      rx_data <= next_rx_data;
      rx_nack <= next_rx_nack;
    end
  end
endmodule : tw_master

//--- tw_assertions.sv
// Purpose: checks the slave's drive of the two-wire link
// Assumes: one slave on the link, strap value given as A0
// Notes: a small framer follows bits and bytes from start conditions
`timescale 1ns/100ps
module tw_assertions import tw_pkg::*; #(
  parameter logic A0 = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // link lines
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q, sda_q, next_scl_q, next_sda_q; // delayed line levels
  logic [3:0] cnt, next_cnt; // bits taken in this byte, 8 means ack next
  logic [1:0] byte_i, next_byte_i; // byte number since start, saturates
  logic [7:0] sh, next_sh; // bits of the byte, msb first
  logic rd, next_rd; // own read header seen
  logic ownw, next_ownw; // own write header seen
  wire logic rise = scl && !scl_q; // clock rise
  wire logic start = scl && scl_q && sda_q && !sda; // data falls while clock high
  wire logic hit = (sh[7:1] == {ADDR_HI, A0}); // header names this slave
  wire logic ack_rise = rise && (cnt == 4'h8); // rise of the ninth bit

  // framer next state
  always_comb begin
    next_scl_q = scl;
    next_sda_q = sda;
    next_cnt = cnt;
    next_byte_i = byte_i;
    next_sh = sh;
    next_rd = rd;
    next_ownw = ownw;
    if (start) begin // a start restarts the framing
      next_cnt = 4'h0;
      next_byte_i = 2'h0;
      next_rd = 1'b0;
      next_ownw = 1'b0;
    end else if (ack_rise) begin
      next_cnt = 4'h0;
      if (byte_i != 2'h3) next_byte_i = byte_i + 2'h1;
      if (byte_i == 2'h0) begin // header decides the direction
        next_rd = hit & sh[0];
        next_ownw = hit & ~sh[0];
      end
    end else if (rise) begin
      next_cnt = cnt + 4'h1;
      next_sh = {sh[6:0], sda};
    end
  end

  // framer registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 4'h0;
      byte_i <= 2'h0;
      sh <= 8'h00;
      rd <= 1'b0;
      ownw <= 1'b0;
    end else begin
      scl_q <= next_scl_q;
      sda_q <= next_sda_q;
      cnt <= next_cnt;
      byte_i <= next_byte_i;
      sh <= next_sh;
      rd <= next_rd;
      ownw <= next_ownw;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ack_only_low: assert property (s_sda_oe |-> !s_sda_out)
    else $error("slave drives data high");
  a_slave_still_high: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("slave data changed while clock high");
  a_own_addr_ack: assert property (ack_rise && byte_i == 2'h0 && hit |-> !sda)
    else $error("own header not acknowledged");
  a_foreign_nack: assert property (ack_rise && byte_i == 2'h0 && !hit && sh != GEN_CALL |-> sda)
    else $error("foreign header acknowledged");
  a_index_ack: assert property (ack_rise && byte_i == 2'h1 && ownw |-> !sda)
    else $error("index byte not acknowledged");
  a_write_quiet: assert property (rise && cnt != 4'h8 && !rd |-> !s_sda_oe)
    else $error("slave drives data in a write bit");
  a_read_ack_free: assert property (ack_rise && byte_i != 2'h0 && rd |-> !s_sda_oe)
    else $error("slave holds data during master ack");
  a_ack_held: assert property (ack_rise && s_sda_oe |-> s_sda_oe [*8])
    else $error("ack drop while clock high");
endmodule : tw_assertions

//--- tb_two_wire_register_access_slave.sv
// Purpose: bench joining the two-wire master and slave through one link
// Assumes: core registers modelled here, address strap tied high
// Notes: expected answers are queued at issue and matched on done
`timescale 1ns/100ps
module tb_two_wire_register_access_slave import tw_pkg::*;;
  logic clk = 1'b0; // system clock
  logic nrst = 1'b0; // reset, active low
  logic cmd_valid = 1'b0; // command port
  logic [1:0] cmd_op = OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic cmd_ready, done, rx_nack, index_valid, wr_strobe; // design answers
  logic [7:0] rx_data, reg_index, wr_data, rd_data;
  logic [7:0] core_mem [0:23]; // core contents as stored by the slave
  logic [7:0] shadow [0:23]; // expected contents
  logic [9:0] notes [$]; // check flag, read flag, value
  logic [9:0] nt; // note taken off the queue
  logic [15:0] wq [$]; // expected index and data of stores
  int err_count = 0;
  int checked = 0;
  int seed = 66087;
  tw_if link ();

  tw_master tw_master_inst (.clk(clk), .nrst(nrst), .bus(link), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack), .cmd_ready(cmd_ready),
    .done(done), .rx_data(rx_data), .rx_nack(rx_nack));
  tw_slave tw_slave_inst (.clk(clk), .nrst(nrst), .bus(link), .addr_sel(1'b1),
    .reg_index(reg_index), .index_valid(index_valid), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_data(rd_data));
  tw_assertions #(.A0(1'b1)) tw_assertions_inst (.clk(clk), .nrst(nrst),
    .scl_out(link.scl_out), .scl_oe(link.scl_oe), .m_sda_out(link.m_sda_out),
    .m_sda_oe(link.m_sda_oe), .s_sda_out(link.s_sda_out), .s_sda_oe(link.s_sda_oe),
    .scl(link.scl), .sda(link.sda));

  // core read port; junk outside the map so the slave must zero it
  assign rd_data = (reg_index < IDX_LIMIT) ? core_mem[reg_index[4:0]] : 8'hff;

  // clock
  initial forever #12.5 clk = ~clk;

  task automatic wrap_up();
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic idx_ok(input logic [7:0] i);
    return (i < IDX_LIMIT) && (i != IDX_HOLE);
  endfunction : idx_ok

  // one command, held until taken, with its note queued
  task automatic do_cmd(input logic [1:0] op, input logic [7:0] d, input logic nk,
                        input logic [9:0] note);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (cmd_ready !== 1'b1 && n < 5000);
    if (n >= 5000) err_count++;
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    notes.push_back(note);
    @(posedge clk);
    #1 cmd_valid = 1'b0;
  endtask : do_cmd

  task automatic wr(input logic [7:0] d, input logic nk_exp);
    do_cmd(OP_WRITE, d, 1'b0, {2'b10, 7'h00, nk_exp});
  endtask : wr

  task automatic ctl(input logic [1:0] op);
    do_cmd(op, 8'h00, 1'b0, 10'h000);
  endtask : ctl

  // burst write; unsupported targets get nack and keep the index
  task automatic wr_burst(input logic [7:0] idx, input int cnt);
    logic [7:0] d;
    logic ok;
    ctl(OP_START);
    wr({ADDR_HI, 2'b10}, 1'b0);
    wr(idx, 1'b0);
    for (int i = 0; i < cnt; i++) begin
      d = 8'($random(seed));
      ok = idx_ok(idx);
      wr(d, ~ok);
      if (ok) begin
        shadow[idx[4:0]] = d;
        wq.push_back({idx, d});
        idx++;
      end
    end
    ctl(OP_STOP);
  endtask : wr_burst

  // read after index write, by repeated start or by stop and start
  task automatic rd_burst(input logic [7:0] idx, input int cnt, input logic rs);
    ctl(OP_START);
    wr({ADDR_HI, 2'b10}, 1'b0);
    wr(idx, 1'b0);
    if (!rs) ctl(OP_STOP);
    ctl(OP_START);
    wr({ADDR_HI, 2'b11}, 1'b0);
    for (int i = 0; i < cnt; i++) begin
      do_cmd(OP_READ, 8'h00, i == cnt - 1, {2'b11, idx_ok(idx) ? shadow[idx[4:0]] : 8'h00});
      idx++;
    end
    ctl(OP_STOP);
  endtask : rd_burst

  // answers of the master, matched against the oldest note
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) check(17'h1, 17'h0);
      else begin
        nt = notes.pop_front();
        if (nt[9] && nt[8]) check({9'h0, rx_data}, {9'h0, nt[7:0]});
        else if (nt[9]) check({16'h0, rx_nack}, {16'h0, nt[0]});
      end
    end
  end

  // stores into the core, checked in order
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) begin
      if (wq.size() == 0) check(17'h1, 17'h0);
      else check({index_valid, reg_index, wr_data}, {1'b1, wq.pop_front()});
      if (reg_index < IDX_LIMIT) core_mem[reg_index[4:0]] <= wr_data;
    end
  end

  // watchdog
  initial begin
    #2000000;
    err_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    int idx;
    int n;
    for (int i = 0; i < 24; i++) begin
      shadow[i] = 8'($random(seed));
      core_mem[i] = shadow[i];
    end
    core_mem[9] = 8'hff; // the hole must still read as zero
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (8) @(posedge clk);
    check({15'h0, link.scl, link.sda}, 17'h3);
    wr_burst(8'h16, 4);
    rd_burst(8'h16, 3, 1'b1);
    wr_burst(8'h07, 4);
    rd_burst(8'h07, 4, 1'b0);
    for (int k = 0; k < 3; k++) begin
      idx = {$random(seed)} % 24;
      wr_burst(8'(idx), 1);
      rd_burst(8'(idx), 1, k[0]);
    end
    ctl(OP_START);
    wr({ADDR_HI ^ 6'h04, 2'b10}, 1'b1);
    ctl(OP_STOP);
    ctl(OP_START);
    wr({ADDR_HI, 2'b00}, 1'b1);
    ctl(OP_STOP);
    // general call is acked and reloads the low address bit from the strap
    ctl(OP_START);
    wr(GEN_CALL, 1'b0);
    ctl(OP_STOP);
    rd_burst(8'h16, 1, 1'b1);
    n = 0;
    while (notes.size() != 0 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    check(17'(wq.size()), 17'h0);
    check(17'(notes.size()), 17'h0);
    check({15'h0, link.scl, link.sda}, 17'h3);
    wrap_up();
  end
endmodule : tb_two_wire_register_access_slave
